// File: rcp_ctl_model.sv
// Purpose: serial controller model on the far side of the port
// Assumes: 8N1 framing, one bit lasts BIT_CLKS system clocks
// Notes: idle line held high; received bytes collect in got
`timescale 1ns/1ps
module rcp_ctl_model #(
  parameter int BIT_CLKS = 256
)(
  input  wire logic clk_sys, // System clock
  output logic      rxd,     // Line into the port
  input  wire logic txd      // Line out of the port
);
  logic [7:0] got[$];
  initial rxd = 1'b1;

  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(negedge clk_sys);
      rxd = f[i];
      repeat (BIT_CLKS - 1) @(negedge clk_sys);
    end
  endtask : send_byte

  // Samples at bit centres; a frame with a low stop bit is dropped
  always
  begin : rx_loop
    logic [7:0] b;
    @(negedge txd);
    repeat (BIT_CLKS / 2) @(posedge clk_sys);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT_CLKS) @(posedge clk_sys);
      b[i] = txd;
    end
    repeat (BIT_CLKS) @(posedge clk_sys);
    if (txd === 1'b1) got.push_back(b);
  end
endmodule : rcp_ctl_model

// File: rcp_pkg.sv
// Purpose: constants and types for the remote command port
// Assumes: 10 MHz system clock, 16x oversampled serial link
// Notes: keywords and response texts are stored right-aligned, zero padded
package rcp_pkg;
  localparam int CLK_HZ   = 10_000_000;
  localparam int OVS      = 16;
  localparam int BAUD_LO  = 9600;
  localparam int BAUD_MID = 19200;
  localparam int BAUD_HI  = 38400;
  localparam logic [7:0] DIV_LO  = 8'(CLK_HZ / (OVS * BAUD_LO));
  localparam logic [7:0] DIV_MID = 8'(CLK_HZ / (OVS * BAUD_MID));
  localparam logic [7:0] DIV_HI  = 8'(CLK_HZ / (OVS * BAUD_HI));
  localparam logic [3:0] OVS_MID  = 4'(OVS / 2 - 1);
  localparam logic [3:0] OVS_LAST = 4'(OVS - 1);
  localparam logic [3:0] TX_BITS  = 4'ha;
  localparam int RXBUF_LIM = 256;
  localparam int OQ_LIM    = 64;
  localparam int VAL_BIN_N = 4;
  localparam int VAL_TXT_N = 8;
  localparam logic [3:0] TOK_MAX = 4'h8;
  localparam logic [7:0] CH_CR    = 8'h0d;
  localparam logic [7:0] CH_LF    = 8'h0a;
  localparam logic [7:0] CH_SP    = 8'h20;
  localparam logic [7:0] CH_STAR  = 8'h2a;
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_SEMI  = 8'h3b;
  localparam logic [7:0] CH_QM    = 8'h3f;
  localparam logic [7:0] CH_0     = 8'h30;
  localparam logic [7:0] CH_9     = 8'h39;
  localparam logic [7:0] CH_A     = 8'h41;
  localparam logic [7:0] CH_Z     = 8'h5a;
  localparam logic [7:0] CH_LA    = 8'h61;
  localparam logic [7:0] CH_LZ    = 8'h7a;
  localparam logic [7:0] CASE_BIT = 8'h20;

  typedef enum logic [3:0] {KW_NONE, KW_SYST, KW_HEAD, KW_FORM, KW_FETC, KW_READ, KW_MEM,
                            KW_DATA, KW_ON, KW_OFF, KW_ASC, KW_BIN, KW_RST} rcp_kw_e;
  localparam int KW_N = 12;
  localparam logic [63:0] KW_LONG [1:KW_N] = '{"SYSTEM", "HEADER", "FORMAT", "FETCH", "READ",
    "MEMORY", "DATA", "ON", "OFF", "ASCII", "BINARY", "RST"};
  localparam logic [63:0] KW_SHORT [1:KW_N] = '{"SYST", "HEAD", "FORM", "FETC", "READ",
    "MEM", "DATA", "ON", "OFF", "ASC", "BIN", "RST"};

  typedef enum logic [2:0] {TX_HEAD, TX_FORM, TX_ON, TX_OFF, TX_ASC, TX_BIN, TX_NONE} rcp_txt_e;
  localparam logic [119:0] TXT [6] = '{":SYSTEM:HEADER ", ":SYSTEM:FORMAT ", "ON", "OFF", "ASCII",
    "BINARY"};
  localparam logic [3:0] TXT_LEN [6] = '{4'hf, 4'hf, 4'h2, 4'h3, 4'h5, 4'h6};

  typedef enum logic [2:0] {B_IDLE = 3'h0, B_PRE = 3'h1, B_BODY = 3'h3, B_CR = 3'h2,
                            B_LF = 3'h6} rcp_bld_e;
  typedef enum logic [1:0] {P_HDR = 2'h0, P_ARG = 2'h1, P_SKIP = 2'h3} rcp_ph_e;
  typedef enum logic [1:0] {R_IDLE = 2'h0, R_START = 2'h1, R_DATA = 2'h3, R_STOP = 2'h2} rcp_rx_e;
  typedef enum logic [1:0] {J_TXT, J_VAL, J_DUMP} rcp_job_e;

  typedef struct packed {
    logic [31:0] flt;
    logic [63:0] txt;
  } rcp_meas_s;

  function automatic rcp_kw_e kw_match(input logic [63:0] t);
    rcp_kw_e k;
    k = KW_NONE;
    for (int i = 1; i <= KW_N; i++)
    begin
      if (t == KW_LONG[i] || t == KW_SHORT[i]) k = rcp_kw_e'(i);
    end
    return k;
  endfunction : kw_match

  function automatic logic [7:0] txt_byte(input rcp_txt_e t, input logic [3:0] i);
    logic [119:0] w;
    w = TXT[t] >> (8 * (TXT_LEN[t] - 4'h1 - i));
    return w[7:0];
  endfunction : txt_byte
endpackage : rcp_pkg

// File: rcp_remote_port.sv
// Purpose: serial remote command port: receiver, header parser, response builder, output queue
// Assumes: all inputs synchronous to clk_sys; OQ_DEPTH is a power of two
// Notes: How it works
// How it works
// - Serial 8N1 at 9600, 19200 or 38400
// - Only data lines used; DTR, RTS held on
// - Format applies to value queries, auto output
// - Binary value: float, sign byte first
// - Single binary value: four bytes, no terminator
// - Binary dump: values back to back
// - Remote locks keys; first function key releases
// - Lockout ignores local key; go-to-local releases
// - Remote entry leaves settings screen
// - Query checked, then response built
// - Header switch, off after power-on
// - Erroneous query yields no response
// - Query-only responses never carry headers
// - Keywords exact long or short, any case
// - Response keywords full form, upper case
// - Simple, compound and asterisk headers recognised
// - Trailing question mark marks a query
// - Accept CR or CR LF; send CR LF
// - Bytes beyond 256 per message dropped
// - Queue overflow: query error, queue cleared
`timescale 1ns/1ps
module rcp_remote_port
  import rcp_pkg::*;
#(
  parameter int OQ_DEPTH = OQ_LIM
)(
  input  wire logic       clk_sys,            // System clock
  input  wire logic       rstn,               // Async reset, active low
  input  wire logic       rxd,                // Serial receive data
  output logic            txd,                // Serial transmit data
  output logic            dtr_o,              // Terminal ready, always on
  output logic            rts_o,              // Request to send, always on
  input  wire logic [1:0] baud_sel,           // 0 low, 1 mid, 2 high rate
  input  wire logic       if_printer,         // Interface set to printer
  input  wire rcp_meas_s  meas,               // Latest measured value
  input  wire logic       meas_strobe,        // Automatic output request
  input  wire rcp_meas_s  mem_val,            // Stored value at mem_idx
  input  wire logic [7:0] mem_count,          // Number of stored values
  output logic      [7:0] mem_idx,            // Stored value index
  input  wire logic       first_function_key, // Local key press
  input  wire logic       settings_screen,    // Settings screen shown
  input  wire logic       llo_req,            // Local lockout request
  input  wire logic       gtl_req,            // Go-to-local request
  output logic            remote_indicator,   // Remote state shown
  output logic            keys_locked,        // Keys other than first key disabled
  output logic            goto_meas,          // Return to measurement screen
  output logic            trig_read,          // Trigger for read query
  output logic            cmd_error,          // Command error pulse
  output logic            query_error,        // Query error pulse
  output logic            hdr_on,             // Response header switch
  output logic            fmt_bin             // Binary transfer format
);
  localparam int AW = $clog2(OQ_DEPTH);
  localparam logic [AW:0] CNT_FULL = (AW + 1)'(OQ_DEPTH);
  localparam logic [8:0]  RX_LIM9  = 9'(RXBUF_LIM);

  typedef struct packed {
    logic [7:0]                 div;
    rcp_rx_e                    rx_st;
    logic [3:0]                 rx_cnt;
    logic [2:0]                 rx_bit;
    logic [7:0]                 rx_sh;
    logic [8:0]                 rx_len;
    rcp_ph_e                    ph;
    logic [63:0]                tok;
    logic [3:0]                 tok_n;
    logic                       std;
    logic                       qry;
    logic [1:0]                 np;
    rcp_kw_e                    p0;
    rcp_kw_e                    p1;
    rcp_kw_e                    arg;
    logic                       hdr_on;
    logic                       fmt_bin;
    logic                       remote;
    logic                       llo;
    rcp_bld_e                   bst;
    rcp_job_e                   jk;
    rcp_txt_e                   pre;
    rcp_txt_e                   sel;
    logic [3:0]                 bidx;
    logic [7:0]                 mi;
    logic [OQ_DEPTH-1:0][7:0]   oq;
    logic [AW-1:0]              wp;
    logic [AW-1:0]              rp;
    logic [AW:0]                cnt;
    logic                       tx_busy;
    logic [9:0]                 tx_sh;
    logic [3:0]                 tx_cnt;
    logic [3:0]                 tx_n;
    logic                       txd;
    logic                       cmd_err;
    logic                       qry_err;
    logic                       trig;
    logic                       goto_m;
  } rcp_st_s;

  rcp_st_s    st_ff;
  rcp_st_s    nxt_st;
  logic [1:0] rst_sync_ff;
  logic       rst_ns;
  logic       tick;
  logic       acc;
  logic       alnum;
  logic       uend;
  logic       e;
  logic       close;
  logic       job_go;
  logic       push;
  logic       pop;
  logic       ovf;
  logic       last_b;
  logic       last_i;
  logic [7:0] ch;
  logic [7:0] up;
  logic [7:0] push_b;
  logic [7:0] dv;
  rcp_kw_e    kw;
  rcp_job_e   gk;
  rcp_txt_e   gsel;
  rcp_txt_e   gpre;
  rcp_meas_s  v;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn) rst_sync_ff <= 2'h0;
    else rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_ns = rst_sync_ff[1];

  always_comb
  begin
    nxt_st = st_ff;
    {nxt_st.cmd_err, nxt_st.qry_err, nxt_st.trig, nxt_st.goto_m} = 4'h0;
    unique case (baud_sel)
      2'h1: dv = DIV_MID;
      2'h2: dv = DIV_HI;
      default: dv = DIV_LO;
    endcase
    tick = (st_ff.div == 8'h0);
    nxt_st.div = tick ? dv - 8'h1 : st_ff.div - 8'h1;
    ch = st_ff.rx_sh;
    acc = 1'b0;
    if (tick)
    begin
      unique case (st_ff.rx_st)
        R_IDLE: if (!rxd) nxt_st.rx_st = R_START;
        R_START:
        begin
          nxt_st.rx_cnt = st_ff.rx_cnt + 4'h1;
          if (st_ff.rx_cnt == OVS_MID)
          begin
            nxt_st.rx_st = rxd ? R_IDLE : R_DATA;
            nxt_st.rx_cnt = 4'h0;
            nxt_st.rx_bit = 3'h0;
          end
        end
        R_DATA:
        begin
          nxt_st.rx_cnt = st_ff.rx_cnt + 4'h1;
          if (st_ff.rx_cnt == OVS_LAST)
          begin
            nxt_st.rx_sh = {rxd, st_ff.rx_sh[7:1]};
            nxt_st.rx_bit = st_ff.rx_bit + 3'h1;
            if (st_ff.rx_bit == 3'h7) nxt_st.rx_st = R_STOP;
          end
        end
        R_STOP:
        begin
          nxt_st.rx_cnt = st_ff.rx_cnt + 4'h1;
          if (st_ff.rx_cnt == OVS_LAST)
          begin
            nxt_st.rx_st = R_IDLE;
            // A low stop bit drops the frame; a full message buffer drops all but CR
            acc = rxd && !if_printer && (ch == CH_CR || st_ff.rx_len < RX_LIM9);
          end
        end
      endcase
    end

    // Local release first; a byte arriving in the same cycle re-enters remote only if remote was already off
    if (gtl_req)
    begin
      nxt_st.remote = 1'b0;
      nxt_st.llo = 1'b0;
    end
    else if (first_function_key && !st_ff.llo) nxt_st.remote = 1'b0;
    if (llo_req) nxt_st.llo = 1'b1;

    up = (ch >= CH_LA && ch <= CH_LZ) ? ch - CASE_BIT : ch;
    alnum = (up >= CH_A && up <= CH_Z) || (up >= CH_0 && up <= CH_9);
    uend = (ch == CH_CR || ch == CH_SEMI);
    kw = kw_match(st_ff.tok);
    e = 1'b0;
    close = 1'b0;
    job_go = 1'b0;
    gk = J_VAL;
    gsel = TX_ON;
    gpre = TX_NONE;
    if (acc)
    begin
      nxt_st.rx_len = (ch == CH_CR) ? 9'h0 : st_ff.rx_len + 9'h1;
      if (!st_ff.remote)
      begin
        nxt_st.remote = 1'b1;
        nxt_st.goto_m = settings_screen;
      end
    end
    if (acc && ch != CH_LF && st_ff.ph != P_SKIP)
    begin
      if (alnum)
      begin
        if (st_ff.tok_n == TOK_MAX || st_ff.qry) e = 1'b1;
        else
        begin
          nxt_st.tok = {st_ff.tok[55:0], up};
          nxt_st.tok_n = st_ff.tok_n + 4'h1;
        end
      end
      else if (ch == CH_STAR)
      begin
        e = st_ff.ph != P_HDR || st_ff.std || st_ff.np != 2'h0 || st_ff.tok_n != 4'h0;
        nxt_st.std = 1'b1;
      end
      else if (ch == CH_QM)
      begin
        e = st_ff.ph != P_HDR || st_ff.tok_n == 4'h0 || st_ff.qry;
        nxt_st.qry = 1'b1;
      end
      else if (ch == CH_COLON)
      begin
        if (st_ff.ph != P_HDR || st_ff.qry) e = 1'b1;
        else if (st_ff.tok_n == 4'h0) e = st_ff.np != 2'h0 || st_ff.std;
        else close = 1'b1;
      end
      else if (ch == CH_SP)
      begin
        if (st_ff.ph == P_HDR)
        begin
          close = 1'b1;
          nxt_st.ph = P_ARG;
        end
      end
      else if (uend) close = 1'b1;
      else e = 1'b1;
      if (close)
      begin
        nxt_st.tok = '0;
        nxt_st.tok_n = 4'h0;
        if (st_ff.ph == P_HDR)
        begin
          // Empty or unknown header element is an error
          if (st_ff.tok_n == 4'h0 || kw == KW_NONE || st_ff.np == 2'h2) e = 1'b1;
          if (st_ff.np == 2'h0) nxt_st.p0 = kw;
          else nxt_st.p1 = kw;
          nxt_st.np = st_ff.np + 2'h1;
        end
        else if (st_ff.tok_n != 4'h0)
        begin
          nxt_st.arg = kw;
          if (kw == KW_NONE) e = 1'b1;
        end
      end
      if (uend && !e)
      begin
        if (st_ff.std)
        begin
          if (nxt_st.p0 == KW_RST && nxt_st.np == 2'h1 && !st_ff.qry)
          begin
            nxt_st.hdr_on = 1'b0;
            nxt_st.fmt_bin = 1'b0;
          end
          else e = 1'b1;
        end
        else if (nxt_st.np == 2'h2 && nxt_st.p0 == KW_SYST && (nxt_st.p1 == KW_HEAD || nxt_st.p1 == KW_FORM))
        begin
          if (st_ff.qry)
          begin
            job_go = nxt_st.arg == KW_NONE;
            e = nxt_st.arg != KW_NONE;
            gk = J_TXT;
            if (st_ff.hdr_on) gpre = (nxt_st.p1 == KW_HEAD) ? TX_HEAD : TX_FORM;
            if (nxt_st.p1 == KW_HEAD) gsel = st_ff.hdr_on ? TX_ON : TX_OFF;
            else gsel = st_ff.fmt_bin ? TX_BIN : TX_ASC;
          end
          else if (nxt_st.p1 == KW_HEAD && (nxt_st.arg == KW_ON || nxt_st.arg == KW_OFF))
            nxt_st.hdr_on = (nxt_st.arg == KW_ON);
          else if (nxt_st.p1 == KW_FORM && (nxt_st.arg == KW_ASC || nxt_st.arg == KW_BIN))
            nxt_st.fmt_bin = (nxt_st.arg == KW_BIN);
          else e = 1'b1;
        end
        else if (st_ff.qry && nxt_st.arg == KW_NONE && nxt_st.np == 2'h1
                 && (nxt_st.p0 == KW_FETC || nxt_st.p0 == KW_READ))
        begin
          job_go = 1'b1;
          nxt_st.trig = (nxt_st.p0 == KW_READ);
        end
        else if (st_ff.qry && nxt_st.arg == KW_NONE && nxt_st.np == 2'h2 && nxt_st.p0 == KW_MEM
                 && nxt_st.p1 == KW_DATA && mem_count != 8'h0)
        begin
          job_go = 1'b1;
          gk = J_DUMP;
        end
        else e = 1'b1;
      end
      if (e)
      begin
        nxt_st.cmd_err = 1'b1;
        job_go = 1'b0;
        nxt_st.ph = P_SKIP;
      end
    end
    if (acc && ((uend && st_ff.ph != P_SKIP) || ch == CH_CR))
    begin
      nxt_st.tok = '0;
      nxt_st.tok_n = 4'h0;
      nxt_st.np = 2'h0;
      nxt_st.std = 1'b0;
      nxt_st.qry = 1'b0;
      nxt_st.arg = KW_NONE;
      // After an error the rest of the line is ignored up to CR
      nxt_st.ph = (e && ch != CH_CR) ? P_SKIP : P_HDR;
    end
    if (!job_go && meas_strobe) job_go = 1'b1;

    push = 1'b0;
    push_b = 8'h0;
    last_b = 1'b0;
    last_i = st_ff.jk != J_DUMP || st_ff.mi == mem_count - 8'h1;
    v = (st_ff.jk == J_DUMP) ? mem_val : meas;
    unique case (st_ff.bst)
      B_IDLE:
      begin
        if (job_go)
        begin
          nxt_st.bst = (gpre == TX_NONE) ? B_BODY : B_PRE;
          nxt_st.jk = gk;
          nxt_st.pre = gpre;
          nxt_st.sel = gsel;
          nxt_st.bidx = 4'h0;
          nxt_st.mi = 8'h0;
        end
      end
      B_PRE:
      begin
        push = 1'b1;
        push_b = txt_byte(st_ff.pre, st_ff.bidx);
        last_b = st_ff.bidx == TXT_LEN[st_ff.pre] - 4'h1;
        nxt_st.bidx = last_b ? 4'h0 : st_ff.bidx + 4'h1;
        if (last_b) nxt_st.bst = B_BODY;
      end
      B_BODY:
      begin
        push = 1'b1;
        if (st_ff.jk == J_TXT)
        begin
          push_b = txt_byte(st_ff.sel, st_ff.bidx);
          last_b = st_ff.bidx == TXT_LEN[st_ff.sel] - 4'h1;
        end
        else if (st_ff.fmt_bin)
        begin
          push_b = 8'(v.flt >> (8 * (VAL_BIN_N - 1 - int'(st_ff.bidx))));
          last_b = st_ff.bidx == 4'(VAL_BIN_N - 1);
        end
        else if (st_ff.bidx == 4'(VAL_TXT_N))
        begin
          push_b = CH_COMMA;
          last_b = 1'b1;
        end
        else
        begin
          push_b = 8'(v.txt >> (8 * (VAL_TXT_N - 1 - int'(st_ff.bidx))));
          last_b = st_ff.bidx == 4'(VAL_TXT_N - 1) && last_i;
        end
        nxt_st.bidx = last_b ? 4'h0 : st_ff.bidx + 4'h1;
        if (last_b && !last_i) nxt_st.mi = st_ff.mi + 8'h1;
        else if (last_b) nxt_st.bst = (st_ff.jk != J_TXT && st_ff.fmt_bin) ? B_IDLE : B_CR;
      end
      B_CR:
      begin
        push = 1'b1;
        push_b = CH_CR;
        nxt_st.bst = B_LF;
      end
      B_LF:
      begin
        push = 1'b1;
        push_b = CH_LF;
        nxt_st.bst = B_IDLE;
      end
      default: nxt_st.bst = B_IDLE;
    endcase
    if (job_go && st_ff.bst != B_IDLE) nxt_st.qry_err = 1'b1;

    pop = !st_ff.tx_busy && st_ff.cnt != '0;
    ovf = push && st_ff.cnt == CNT_FULL;
    if (ovf)
    begin
      nxt_st.qry_err = 1'b1;
      nxt_st.wp = '0;
      nxt_st.rp = '0;
      nxt_st.cnt = '0;
      nxt_st.bst = B_IDLE;
    end
    else
    begin
      if (push)
      begin
        nxt_st.oq[st_ff.wp] = push_b;
        nxt_st.wp = st_ff.wp + AW'(1);
      end
      if (pop) nxt_st.rp = st_ff.rp + AW'(1);
      nxt_st.cnt = st_ff.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    end
    if (pop)
    begin
      nxt_st.tx_busy = 1'b1;
      nxt_st.tx_sh = {1'b1, st_ff.oq[st_ff.rp], 1'b0};
      nxt_st.tx_cnt = 4'h0;
      nxt_st.tx_n = TX_BITS;
    end
    else if (st_ff.tx_busy && tick)
    begin
      nxt_st.tx_cnt = st_ff.tx_cnt + 4'h1;
      if (st_ff.tx_cnt == OVS_LAST)
      begin
        nxt_st.tx_sh = {1'b1, st_ff.tx_sh[9:1]};
        nxt_st.tx_n = st_ff.tx_n - 4'h1;
        if (st_ff.tx_n == 4'h1) nxt_st.tx_busy = 1'b0;
      end
    end
    nxt_st.txd = nxt_st.tx_busy ? nxt_st.tx_sh[0] : 1'b1;
  end

  always_ff @(posedge clk_sys or negedge rst_ns)
  begin
    if (!rst_ns)
    begin
      st_ff <= '0;
      st_ff.txd <= 1'b1;
    end
    else st_ff <= nxt_st;
  end

  assign txd = st_ff.txd;
  assign dtr_o = 1'b1;
  assign rts_o = 1'b1;
  assign mem_idx = st_ff.mi;
  assign remote_indicator = st_ff.remote;
  assign keys_locked = st_ff.remote;
  assign goto_meas = st_ff.goto_m;
  assign trig_read = st_ff.trig;
  assign cmd_error = st_ff.cmd_err;
  assign query_error = st_ff.qry_err;
  assign hdr_on = st_ff.hdr_on;
  assign fmt_bin = st_ff.fmt_bin;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_ns);

  sequence s_crlf;
    st_ff.bst == B_CR ##1 st_ff.bst == B_LF ##1 st_ff.bst == B_IDLE;
  endsequence
  a_resp_crlf: assert property (st_ff.bst == B_CR && st_ff.cnt < CNT_FULL - 1 |-> s_crlf)
    else $error("response terminator not CR LF");
  a_link_lines: assert property (dtr_o && rts_o)
    else $error("DTR or RTS dropped");
  a_hdr_boot: assert property ($rose(rst_ns) |-> !hdr_on)
    else $error("header switch on after reset");
  a_bin_sign: assert property (st_ff.bst == B_BODY && st_ff.jk != J_TXT && st_ff.fmt_bin && st_ff.bidx == 4'h0
    |-> push_b == v.flt[31:24]) else $error("binary value not sign byte first");
  a_bin_noterm: assert property (st_ff.bst == B_BODY && st_ff.jk == J_VAL && st_ff.fmt_bin
    && st_ff.bidx == 4'h3 |=> st_ff.bst == B_IDLE) else $error("binary value followed by bytes");
  a_dump_tight: assert property (st_ff.bst == B_BODY && st_ff.jk == J_DUMP && st_ff.fmt_bin
    && st_ff.bidx == 4'h3 && !last_i && !ovf |=> st_ff.bst == B_BODY && st_ff.bidx == 4'h0
    && st_ff.mi == $past(st_ff.mi) + 8'h1) else $error("gap between dumped values");
  a_oq_flush: assert property (ovf |=> st_ff.cnt == '0 && query_error)
    else $error("overflow did not flush queue");
  a_local_key: assert property (st_ff.remote && !st_ff.llo && first_function_key && !acc |=> !st_ff.remote)
    else $error("local key ignored");
  a_lockout: assert property (st_ff.remote && st_ff.llo && !gtl_req |=> st_ff.remote)
    else $error("remote left under lockout");
  a_screen_exit: assert property ($rose(st_ff.remote) |-> goto_meas == $past(settings_screen))
    else $error("settings screen not left");
  a_rx_cap: assert property (st_ff.rx_len <= RX_LIM9)
    else $error("receive count beyond capacity");
  a_err_silent: assert property (cmd_error && $past(st_ff.bst) == B_IDLE && !$past(meas_strobe)
    |-> st_ff.bst == B_IDLE) else $error("response after error");
  a_no_qhdr: assert property (st_ff.bst == B_PRE |-> st_ff.jk == J_TXT)
    else $error("header on query-only response");
endmodule : rcp_remote_port

// File: tb_remote_command_port.sv
// Purpose: self-checking bench for the remote command port
// Assumes: fastest rate selected to keep the run short
// Notes: expected bytes come from the bench's own queue model
`timescale 1ns/1ps
module tb_remote_command_port;
  import rcp_pkg::*;
  logic       clk_sys = 1'b0;
  logic       rstn = 1'b0;
  logic       rxd, txd, dtr_o, rts_o, first_function_key, settings_screen, llo_req, gtl_req, meas_strobe;
  logic       remote_indicator, keys_locked, goto_meas, cmd_error, hdr_on, fmt_bin, trig_read, query_error;
  logic [7:0] mem_idx;
  rcp_meas_s  meas;
  int         errors = 0;
  int         checked = 0;
  int         gm_cnt = 0;
  int         ce_cnt = 0;
  int         tr_cnt = 0;
  int         qe_cnt = 0;
  int unsigned seed = 28553;
  logic [7:0] exp_q[$];

  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    if (goto_meas === 1'b1) gm_cnt++;
    if (cmd_error === 1'b1) ce_cnt++;
    if (trig_read === 1'b1) tr_cnt++;
    if (query_error === 1'b1) qe_cnt++;
  end

  rcp_ctl_model #(.BIT_CLKS(16 * 16)) u_rcp_ctl_model (.clk_sys(clk_sys), .rxd(rxd), .txd(txd));
  rcp_remote_port u_rcp_remote_port (.clk_sys(clk_sys), .rstn(rstn), .rxd(rxd), .txd(txd),
    .dtr_o(dtr_o), .rts_o(rts_o), .baud_sel(2'h2), .if_printer(1'b0), .meas(meas),
    .meas_strobe(meas_strobe), .mem_val('0), .mem_count(8'h00), .mem_idx(mem_idx),
    .first_function_key(first_function_key), .settings_screen(settings_screen),
    .llo_req(llo_req), .gtl_req(gtl_req), .remote_indicator(remote_indicator),
    .keys_locked(keys_locked), .goto_meas(goto_meas), .trig_read(trig_read), .cmd_error(cmd_error),
    .query_error(query_error), .hdr_on(hdr_on), .fmt_bin(fmt_bin));

  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic report_and_stop();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic send_msg(input string s);
    for (int i = 0; i < s.len(); i++) u_rcp_ctl_model.send_byte(s[i]);
  endtask : send_msg

  // Extra quiet time catches trailing bytes such as an unwanted terminator
  task automatic expect_resp();
    int n;
    n = 0;
    while (u_rcp_ctl_model.got.size() < exp_q.size() && n < 40000)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (u_rcp_ctl_model.got.size() < exp_q.size())
    begin
      errors++;
      report_and_stop();
    end
    repeat (3000) @(posedge clk_sys);
    chk(32'(u_rcp_ctl_model.got.size()), 32'(exp_q.size()));
    foreach (exp_q[i]) if (i < u_rcp_ctl_model.got.size()) chk(u_rcp_ctl_model.got[i], exp_q[i]);
    u_rcp_ctl_model.got.delete();
    exp_q.delete();
  endtask : expect_resp

  task automatic pulse(ref logic s);
    @(negedge clk_sys) s = 1'b1;
    @(negedge clk_sys) s = 1'b0;
    repeat (4) @(negedge clk_sys);
  endtask : pulse

  initial
  begin
    {first_function_key, llo_req, gtl_req, meas_strobe} = 4'h0;
    settings_screen = 1'b1;
    meas = {xs(), xs(), xs()};
    repeat (4) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk(dtr_o & rts_o, 1);
    chk(hdr_on, 0);
    for (int i = 7; i >= 0; i--) exp_q.push_back(meas.txt[i*8+:8]);
    exp_q.push_back(CH_CR);
    exp_q.push_back(CH_LF);
    send_msg("fetc?\r");
    // Next message overlaps the answer to keep the run short
    fork
      expect_resp();
      send_msg("syst:form bin;");
    join
    chk({remote_indicator, keys_locked}, 2'h3);
    chk(gm_cnt, 1);
    chk(fmt_bin, 1);
    @(negedge clk_sys);
    meas = {xs(), xs(), xs()};
    for (int i = 3; i >= 0; i--) exp_q.push_back(meas.flt[i*8+:8]);
    send_msg("READ?\r");
    expect_resp();
    chk(tr_cnt, 1);
    chk(mem_idx, 8'h0);
    pulse(first_function_key);
    chk(remote_indicator, 0);
    @(negedge clk_sys);
    meas = {xs(), xs(), xs()};
    for (int i = 3; i >= 0; i--) exp_q.push_back(meas.flt[i*8+:8]);
    fork
      send_msg("FET?\r");
      begin
        pulse(meas_strobe);
        expect_resp();
      end
    join
    // A late answer to the bad query would land here
    expect_resp();
    chk(ce_cnt, 1);
    pulse(llo_req);
    pulse(first_function_key);
    chk(remote_indicator, 1);
    pulse(gtl_req);
    chk({remote_indicator, keys_locked}, 2'h0);
    chk(qe_cnt, 0);
    report_and_stop();
  end
endmodule : tb_remote_command_port
